/* File: rtl/uvs_pkg.sv */
// uvs_pkg: shared constants of the uv sensor bus port
// assumes: byte-wide two-wire bus, addresses given as 8-bit address bytes
package uvs_pkg;
  // ----------------------------------------
  // bus address bytes (7-bit address plus direction bit)
  // ----------------------------------------
  localparam logic [7:0] ARA_BYTE = 8'h18; // alert response address, write form
  localparam logic [7:0] CMD_BYTE = 8'h70; // command register address byte
  localparam logic [7:0] LSB_BYTE = 8'h71; // count low byte address byte
  localparam logic [7:0] MSB_BYTE = 8'h73; // count high byte address byte
  localparam logic [7:0] ARA_RD_BYTE = ARA_BYTE | 8'h01; // alert response read
  localparam logic [7:0] DEV_REPLY = CMD_BYTE; // own address returned on alert read
  // ----------------------------------------
  // command byte layout
  // ----------------------------------------
  localparam int SHUTDOWN_POS = 0; // shutdown_bit
  localparam int IT_LSB_POS = 2; // integration_time_low_bit
  localparam int IT_MSB_POS = 3; // integration_time_high_bit
  localparam int STEP_SEL_POS = 4; // alert_step_select
  localparam int ALERT_EN_POS = 5; // alert enable
  localparam logic [7:0] CMD_RESET = 8'h02; // bit 1 set, awake, half time, no alert
  localparam logic [7:0] CMD_SHUTDOWN = 8'h01; // shutdown encoding
  localparam logic [1:0] IT_HALF = 2'h0; // 0x00
  localparam logic [1:0] IT_SINGLE = 2'h1; // 0x04
  localparam logic [1:0] IT_DOUBLE = 2'h2; // 0x08
  localparam logic [1:0] IT_QUAD = 2'h3; // 0x0C
  // ----------------------------------------
  // alert step sizes, in output counts
  // ----------------------------------------
  localparam logic [15:0] STEP_SMALL = 16'h0066; // 102 counts
  localparam logic [15:0] STEP_LARGE = 16'h0091; // 145 counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // bus bits per byte
  // ----------------------------------------
  // bus slave states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } uvs_state_t;
endpackage : uvs_pkg

/* File: rtl/uvs_sync.sv */
// uvs_sync: two-flop synchroniser for one pin level
// assumes: input asynchronous to clk, output read only in the clk domain
`timescale 1ns/10ps
module uvs_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  import uvs_pkg::*;
  logic meta; // first stage, read only by the second
  logic next_meta; // next first stage
  logic next_level; // next second stage
  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_meta = rst_n ? pin : INIT;
    next_level = rst_n ? meta : INIT;
  end
  // register both stages
  always_ff @(posedge clk) begin
    meta <= next_meta;
    level <= next_level;
  end
endmodule // uvs_sync

/* File: rtl/uvs_top.sv */
// uvs_top: bus slave, command byte, count registers and alert of a uv sensor
// assumes: scl and sda come from the bus pins, raw counts come from the converter
`timescale 1ns/10ps
module uvs_top #(
  parameter logic POWER_ON_ALERT = 1'b1 // alert pending after power-up
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alert_o,
  output logic alert_oe,
  input wire logic [15:0] raw_count,
  input wire logic sample_strobe,
  output logic meas_enable,
  output logic [1:0] integration_time_field
);
  import uvs_pkg::*;
  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic scl_s; // synchronised clock line
  logic sda_s; // synchronised data line
  logic scl_d; // previous clock line
  logic sda_d; // previous data line
  uvs_sync #(.INIT(1'b1)) u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_i), .level(scl_s));
  uvs_sync #(.INIT(1'b1)) u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_i), .level(sda_s));
  wire scl_rise = scl_s & ~scl_d; // sample point
  wire scl_fall = ~scl_s & scl_d; // drive point
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s; // data falls, clock high
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s; // data rises, clock high
  // ----------------------------------------
  // bus slave state
  // ----------------------------------------
  uvs_state_t state, next_state; // slave phase
  logic [3:0] bitcnt, next_bitcnt; // bits of the current byte
  logic [7:0] shreg, next_shreg; // shift register, both directions
  logic [7:0] addr_q, next_addr_q; // address byte of this transfer
  logic drive, next_drive; // pull data line low
  logic ara_clr; // alert response acknowledged
  logic cmd_we; // command byte received
  logic mst_ack, next_mst_ack; // master acked the last read byte
  logic [7:0] cmd, next_cmd; // command_settings
  logic [15:0] count, next_count; // count_high_byte : count_low_byte
  logic pending, next_pending; // alert pending
  logic [15:0] ref_cnt, next_ref_cnt; // count at first accepted sample or last alert
  logic have_ref, next_have_ref; // reference taken
  logic [7:0] tx_byte; // byte to send for this address
  logic addr_ok; // address byte gets an ack
  // choose reply byte by address
  always_comb begin
    unique case (addr_q)
      ARA_RD_BYTE: tx_byte = DEV_REPLY;
      LSB_BYTE: tx_byte = count[7:0];
      MSB_BYTE: tx_byte = count[15:8];
      default: tx_byte = 8'hFF;
    endcase
  end
  // address decode on the completed address byte
  always_comb begin
    unique case (shreg)
      ARA_RD_BYTE: addr_ok = pending; // nack once clear
      CMD_BYTE, LSB_BYTE, MSB_BYTE: addr_ok = ~pending; // blocked while pending
      default: addr_ok = 1'b0;
    endcase
  end
  // next values of the bus slave
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_addr_q = addr_q;
    next_drive = drive;
    next_mst_ack = mst_ack;
    ara_clr = 1'b0;
    cmd_we = 1'b0;
    if (bus_stop) begin
      // stop ends any transfer
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (bus_start) begin
      // start or repeated start
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_drive = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_drive = 1'b0;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
            if (state == ST_WR) begin
              // data byte into the command register
              cmd_we = (addr_q == CMD_BYTE);
              next_drive = 1'b1;
              next_state = ST_WR_ACK;
            end else if (addr_ok) begin
              next_addr_q = shreg;
              next_drive = 1'b1;
              next_state = ST_ADDR_ACK;
              ara_clr = (shreg == ARA_RD_BYTE);
            end else begin
              next_state = ST_IDLE; // nack
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (addr_q[0]) begin
              // first read bit goes out on this fall
              next_shreg = tx_byte;
              next_drive = ~tx_byte[7];
              next_state = ST_RD;
            end else begin
              next_drive = 1'b0;
              next_state = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == BITS_PER_BYTE) begin
              next_drive = 1'b0; // let the master answer
              next_state = ST_RD_ACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive = ~shreg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_mst_ack = ~sda_s;
          end else if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (mst_ack) begin
              // master wants another byte of the same register
              next_shreg = tx_byte;
              next_drive = ~tx_byte[7];
              next_state = ST_RD;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE; // unused code falls back to idle
        end
      endcase
    end
  end
  // ----------------------------------------
  // measurement, command and alert
  // ----------------------------------------
  logic [18:0] scaled; // raw count times integration factor
  logic [15:0] sat_cnt; // scaled count, saturated
  logic [15:0] diff; // distance from reference
  logic [15:0] step; // selected step size
  logic take; // sample accepted
  logic alert_set; // alert event
  // scale, compare and flag
  always_comb begin
    scaled = {3'h0, raw_count} << cmd[IT_MSB_POS:IT_LSB_POS];
    sat_cnt = (scaled[18:16] != 3'h0) ? 16'hFFFF : scaled[15:0];
    diff = (sat_cnt > ref_cnt) ? (sat_cnt - ref_cnt) : (ref_cnt - sat_cnt);
    step = cmd[STEP_SEL_POS] ? STEP_LARGE : STEP_SMALL;
    take = sample_strobe & ~cmd[SHUTDOWN_POS]; // no samples in shutdown
    alert_set = take & cmd[ALERT_EN_POS] & have_ref & (diff > step);
    next_cmd = cmd_we ? shreg : cmd;
    next_count = take ? sat_cnt : count;
    next_have_ref = have_ref | take;
    next_ref_cnt = (take && (!have_ref || alert_set)) ? sat_cnt : ref_cnt;
    next_pending = alert_set | (pending & ~ara_clr); // set wins, holds
  end
  // register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      addr_q <= 8'h00;
      drive <= 1'b0;
      mst_ack <= 1'b0;
      cmd <= CMD_RESET;
      count <= 16'h0000;
      ref_cnt <= 16'h0000;
      have_ref <= 1'b0;
      pending <= POWER_ON_ALERT; // power-up alert
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      addr_q <= next_addr_q;
      drive <= next_drive;
      mst_ack <= next_mst_ack;
      cmd <= next_cmd;
      count <= next_count;
      ref_cnt <= next_ref_cnt;
      have_ref <= next_have_ref;
      pending <= next_pending;
    end
  end
  // ----------------------------------------
  // pins and status outputs
  // ----------------------------------------
  assign sda_o = 1'b0; // open drain, only pulls low
  assign sda_oe = drive;
  assign alert_o = 1'b0; // open drain alert, low when pending
  assign alert_oe = pending;
  assign meas_enable = ~cmd[SHUTDOWN_POS];
  assign integration_time_field = cmd[IT_MSB_POS:IT_LSB_POS];
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_STEP_SMALL: assert property (
    take && cmd[ALERT_EN_POS] && have_ref && !cmd[STEP_SEL_POS] && diff > 16'h0066
    |=> alert_oe) else $error("alert missed for small step");
  AST_STEP_LARGE: assert property (
    take && have_ref && cmd[STEP_SEL_POS] && diff <= 16'h0091 && !pending
    && !ara_clr |=> !pending) else $error("alert raised inside large step");
  AST_ALERT_OFF: assert property (
    !cmd[ALERT_EN_POS] && !pending |=> !pending) else $error("alert while disabled");
  AST_ALERT_CAUSE: assert property (
    $rose(alert_oe) |-> $past(sample_strobe) && $past(cmd[ALERT_EN_POS]))
    else $error("alert without sample");
  AST_ARA_REPLY: assert property (
    state == ST_ADDR_ACK && scl_fall && !bus_start && !bus_stop && addr_q == ARA_RD_BYTE
    |=> state == ST_RD && shreg == 8'h70) else $error("wrong alert reply byte");
  AST_BLOCKED: assert property (
    state == ST_ADDR && scl_fall && !bus_start && !bus_stop && bitcnt == 4'h8 && pending
    && shreg != ARA_RD_BYTE |=> state == ST_IDLE && !sda_oe) else $error("ack while pending");
  AST_ARA_CLEAR: assert property (
    ara_clr && !alert_set |=> !alert_oe ##1 (!alert_oe || $past(alert_set)))
    else $error("alert not cleared");
  AST_HOLD: assert property (
    pending && !ara_clr |=> pending) else $error("alert dropped");
  AST_LSB_BYTE: assert property (
    state == ST_ADDR_ACK && scl_fall && !bus_start && !bus_stop && addr_q == LSB_BYTE
    |=> shreg == $past(count[7:0])) else $error("low byte mismatch");
  AST_SHUTDOWN: assert property (
    cmd[SHUTDOWN_POS] && sample_strobe |=> $stable(count)) else $error("sample in shutdown");
  COV_ARA: cover property (ara_clr);
  COV_CMD: cover property (cmd_we);
  COV_MSB: cover property (state == ST_RD && addr_q == MSB_BYTE);
  COV_ALERT: cover property ($rose(alert_oe));
endmodule // uvs_top

/* File: bench/uvs_host.sv */
// uvs_host: bus master model that drives the clock pin and pulls data low
// assumes: bench resolves the open-drain data wire and feeds it back as sda
`timescale 1ns/10ps
module uvs_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // clock idles high, data released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ----------------------------------------
  // bit and frame level
  // ----------------------------------------
  // 48 ns bit: data moves mid low phase, slave answers within the 24 ns low phase
  task automatic put_bit(input logic b, output logic seen);
    scl = 1'b0;
    #12 sda_low = !b;
    #12 scl = 1'b1;
    seen = sda; // sampled at clock rise
    #24;
  endtask
  // 8 bits msb first, then ninth bit released for the ack
  task automatic put_byte(input logic [7:0] b, output logic [7:0] got, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
      got[i] = s;
    end
    put_bit(1'b1, s); // a read ends in master nack
    ack = !s;
  endtask
  // start, address, ack, one byte, stop
  task automatic xfer(input logic [7:0] adr, input logic [7:0] dat, output logic ack,
                      output logic [7:0] got);
    logic [7:0] ign;
    logic a2;
    got = 8'hFF;
    sda_low = 1'b0;
    #24 sda_low = 1'b1; // start: data falls while clock high
    #24;
    put_byte(adr, ign, ack);
    if (ack) begin
      put_byte(adr[0] ? 8'hFF : dat, got, a2);
      ack = adr[0] | a2; // writes need the data ack too
    end
    scl = 1'b0;
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #24 sda_low = 1'b0; // stop: data rises while clock high
    #48;
  endtask
endmodule // uvs_host

/* File: bench/tb_top.sv */
// tb_top: self-checking bench of the uv sensor bus port
// assumes: uvs_host drives the bus, pull-ups on data and alert lines
`timescale 1ns/10ps
module tb_top;
  import uvs_pkg::*;
  logic clk, rst_n, scl, sda_low, sda, sample_strobe, ack;
  logic sda_o, sda_oe, alert_o, alert_oe, alert_pin_n, meas_enable;
  logic [1:0] integration_time_field;
  logic [15:0] raw_count;
  logic [7:0] got;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // open-drain wire: low if either party pulls
  assign sda = !(sda_low | (sda_oe & !sda_o));
  // alert pin with pull-up: low while the device pulls it
  assign alert_pin_n = !(alert_oe & !alert_o);
  uvs_host uvs_host_i (.scl(scl), .sda_low(sda_low), .sda(sda));
  uvs_top uvs_top_i (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .alert_o(alert_o), .alert_oe(alert_oe), .raw_count(raw_count),
    .sample_strobe(sample_strobe), .meas_enable(meas_enable),
    .integration_time_field(integration_time_field)
  );
  // ----------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] adr, input logic [7:0] dat);
    uvs_host_i.xfer(adr, dat, ack, got);
    @(negedge clk);
  endtask
  // one-cycle converter pulse, alert settles next edge
  task automatic sample(input logic [15:0] v);
    @(negedge clk);
    raw_count = v;
    sample_strobe = 1'b1;
    @(negedge clk);
    sample_strobe = 1'b0;
    @(negedge clk);
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    raw_count = 16'h0000;
    sample_strobe = 1'b0;
    do_reset();
    check("alert_pwr", 16'(alert_oe), 16'h0001);
    check("alert_pin", 16'(alert_pin_n), 16'h0000);
    check("cmd_rst", {13'h0, meas_enable, integration_time_field}, 16'h0004);
    bus(CMD_BYTE, 8'h02);
    check("cmd_blocked", 16'(ack), 16'h0000);
    bus(LSB_BYTE, 8'h00);
    check("lsb_blocked", 16'(ack), 16'h0000);
    bus(ARA_RD_BYTE, 8'h00); // host clears alert before configuring
    check("ara_ack", 16'(ack), 16'h0001);
    check("ara_reply", 16'(got), 16'(DEV_REPLY));
    check("alert_clr", 16'(alert_oe), 16'h0000);
    bus(ARA_RD_BYTE, 8'h00); // read once more, expect nack
    check("ara_nack", 16'(ack), 16'h0000);
    // every integration code, then shutdown
    for (int it = 0; it < 4; it++) begin
      bus(CMD_BYTE, {4'h0, 2'(it), 2'b10});
      check("cmd_ack", 16'(ack), 16'h0001);
      check("it_field", 16'(integration_time_field), 16'(it));
    end
    bus(CMD_BYTE, CMD_SHUTDOWN | CMD_RESET);
    check("shutdown", 16'(meas_enable), 16'h0000);
    // a sample while shut down leaves the count alone
    sample(16'h0155);
    bus(LSB_BYTE, 8'h00);
    check("sd_cnt", 16'(got), 16'h0000);
    // single time doubles the half-time count, alert disabled
    bus(CMD_BYTE, 8'h06);
    sample(16'h1234);
    bus(LSB_BYTE, 8'h00);
    check("cnt_lo", 16'(got), 16'h0068);
    bus(MSB_BYTE, 8'h00);
    check("cnt_hi", 16'(got), 16'h0024);
    sample(16'h2000);
    check("alert_off", 16'(alert_oe), 16'h0000);
    // small step: 102 holds, 103 raises
    do_reset();
    bus(ARA_RD_BYTE, 8'h00);
    bus(CMD_BYTE, 8'h22);
    sample(16'd1000);
    sample(16'd1102);
    check("step_small_eq", 16'(alert_oe), 16'h0000);
    sample(16'd1103);
    check("step_small_gt", 16'(alert_oe), 16'h0001);
    bus(LSB_BYTE, 8'h00);
    check("pend_nack", 16'(ack), 16'h0000);
    bus(ARA_RD_BYTE, 8'h00); // poll the alert response address unconditionally to clear the alert
    // large step: 145 holds, 146 raises, alert then sticks
    bus(CMD_BYTE, 8'h32);
    sample(16'd1248);
    check("step_large_eq", 16'(alert_oe), 16'h0000);
    sample(16'd1249);
    check("step_large_gt", 16'(alert_oe), 16'h0001);
    sample(16'd1300); // inside the step: nothing sets it again
    check("alert_hold", 16'(alert_oe), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      if (alert_oe) bus(ARA_RD_BYTE, 8'h00);
    end
    check("alert_rel", 16'(alert_oe), 16'h0000);
    check("alert_pin_rel", 16'(alert_pin_n), 16'h0001);
    give_verdict();
  end
endmodule // tb_top
